// ### core/lbm_cycle_timer.sv
// leaky bucket activity monitor: monitoring cycle timer
// assumes pclk free-running; emits one tick per CYCLE_CLKS clocks
`timescale 1ns/1ns
module lbm_cycle_timer
	import lbm_pkg::*;
#(
	parameter int CYCLE_CLKS_P = CYCLE_CLKS,
	parameter int CNT_W        = 21
)(
	input  wire logic pclk,
	input  wire logic presetn,
	lbm_tick_if.timer t
);

	logic [CNT_W-1:0] count;
	wire              at_end = (count == CNT_W'(CYCLE_CLKS_P - 1));

	// -------------------------------------------------------------------
	// free-running divider
	// -------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count <= '0;
		else
			count <= at_end ? '0 : count + 1'b1;
	end

	assign t.tick = at_end;

	AST_TICK_GAP:
	assert property (@(posedge pclk) disable iff (!presetn)
		t.tick |=> !t.tick)
		else $error("tick pulses back to back");

endmodule : lbm_cycle_timer

// ### core/lbm_decay.sv
// leaky bucket activity monitor: clean-run counter for the decay schedule
// assumes tick from the timer and clean from the core on the same pclk
`timescale 1ns/1ns
module lbm_decay
	import lbm_pkg::*;
(
	input  wire logic pclk,
	input  wire logic presetn,
	lbm_tick_if.decay t
);

	// clean cycles needed per decrement, less one
	function automatic logic [RUN_W-1:0] run_limit(input logic [1:0] c);
		case (c)
			2'h0:    run_limit = 3'h0;
			2'h1:    run_limit = 3'h1;
			2'h2:    run_limit = 3'h3;
			default: run_limit = 3'h7;
		endcase
	endfunction : run_limit

	logic [RUN_W-1:0] run;
	wire  [RUN_W-1:0] limit = run_limit(t.code);

	// >= so that a smaller code written mid-run drains at once
	assign t.drain = t.tick & t.clean & (run >= limit);

	// -------------------------------------------------------------------
	// run counter: a failed cycle restarts the run
	// -------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			run <= '0;
		else if (t.tick)
			run <= (!t.clean || t.drain) ? '0 : run + 1'b1;
	end

	AST_DRAIN_RUN:
	assert property (@(posedge pclk) disable iff (!presetn)
		t.drain |-> (run >= run_limit(t.code)) && t.clean)
		else $error("drain before clean run complete");

	AST_CODE1_SKIP:
	assert property (@(posedge pclk) disable iff (!presetn)
		(t.tick && t.clean && t.code == 2'h1 && run == 3'h0) |-> !t.drain)
		else $error("code 01 drained on first clean cycle");

endmodule : lbm_decay

// ### core/lbm_top.sv
// leaky bucket activity monitor: APB registers, bucket and interrupt
// assumes input_fail comes from detector logic in another timing domain;
// pready is registered so every transfer has exactly one wait-free access
`timescale 1ns/1ns

module lbm_top
	import lbm_pkg::*;
#(
	parameter int CYCLE_CLKS_P = CYCLE_CLKS,
	parameter int CNT_W        = 21
)(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              input_fail,
	output logic                   alarm,
	output logic      [REG_W-1:0]  level,
	output logic                   irq
);

	// -------------------------------------------------------------------
	// submodules
	// -------------------------------------------------------------------
	lbm_tick_if t ();

	lbm_cycle_timer #(
		.CYCLE_CLKS_P (CYCLE_CLKS_P),
		.CNT_W        (CNT_W)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (t)
	);

	lbm_decay u_decay (
		.pclk    (pclk),
		.presetn (presetn),
		.t       (t)
	);

	// -------------------------------------------------------------------
	// configuration and state registers
	// -------------------------------------------------------------------
	logic [REG_W-1:0] upper;
	logic [REG_W-1:0] lower;
	logic [REG_W-1:0] cap;
	logic [REG_W-1:0] decay;
	logic [EV_W-1:0]  irq_stat;
	logic [EV_W-1:0]  irq_en;
	logic [REG_W-1:0] acc;
	logic             fail_m;
	logic             fail_s;
	logic             fail_seen;

	// -------------------------------------------------------------------
	// apb decode
	// -------------------------------------------------------------------
	wire setup  = psel & ~penable;
	wire access = psel & penable & pready;
	wire wr_en  = access & pwrite;

	wire sel_upper = (paddr == lbm_byte_addr(IDX_UPPER));
	wire sel_lower = (paddr == lbm_byte_addr(IDX_LOWER));
	wire sel_cap   = (paddr == lbm_byte_addr(IDX_CAP));
	wire sel_decay = (paddr == lbm_byte_addr(IDX_DECAY));
	wire sel_stat  = (paddr == lbm_byte_addr(IDX_IRQ_STAT));
	wire sel_clr   = (paddr == lbm_byte_addr(IDX_IRQ_CLR));
	wire sel_en    = (paddr == lbm_byte_addr(IDX_IRQ_EN));
	wire sel_level = (paddr == lbm_byte_addr(IDX_LEVEL));

	// writable and readable sets; status and level refuse writes
	wire rw_hit = sel_upper | sel_lower | sel_cap | sel_decay | sel_en;
	wire wr_ok  = rw_hit | sel_clr;
	wire rd_ok  = rw_hit | sel_stat | sel_level | sel_clr;
	wire bad    = pwrite ? ~wr_ok : ~rd_ok;

	wire [REG_W-1:0] wbyte = pwdata[REG_W-1:0];

	// read mux; the clear register reads as zero
	wire [DATA_W-1:0] rd_data =
		sel_upper ? DATA_W'(upper) :
		sel_lower ? DATA_W'(lower) :
		sel_cap   ? DATA_W'(cap) :
		sel_decay ? DATA_W'(decay) :
		sel_stat  ? DATA_W'(irq_stat) :
		sel_en    ? DATA_W'(irq_en) :
		sel_level ? DATA_W'({alarm, acc}) :
		'0;

	// -------------------------------------------------------------------
	// apb answer: ready in the first access cycle
	// -------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & bad;
			prdata  <= (setup & ~pwrite) ? rd_data : '0;
		end
	end

	// -------------------------------------------------------------------
	// configuration writes
	// -------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			upper  <= RST_UPPER;
			lower  <= RST_LOWER;
			cap    <= RST_CAP;
			decay  <= RST_DECAY;
			irq_en <= RST_IRQ;
		end
		else if (wr_en)
		begin
			if (sel_upper) upper <= wbyte;
			if (sel_lower) lower <= wbyte;
			if (sel_cap) cap <= wbyte;
			// unused upper bits are kept as zero
			if (sel_decay) decay <= {6'h00, wbyte[DECAY_W-1:0]};
			if (sel_en) irq_en <= wbyte[EV_W-1:0];
		end
	end

	assign t.code = decay[DECAY_LSB +: DECAY_W];

	// -------------------------------------------------------------------
	// failure input: synchronise, then hold until the cycle ends
	// -------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fail_m    <= 1'b0;
			fail_s    <= 1'b0;
			fail_seen <= 1'b0;
		end
		else
		begin
			fail_m    <= input_fail;
			fail_s    <= fail_m;
			fail_seen <= t.tick ? 1'b0 : (fail_seen | fail_s);
		end
	end

	// a single failed sample anywhere in the cycle marks it failed
	wire cyc_failed = fail_seen | fail_s;
	assign t.clean = ~cyc_failed;

	// -------------------------------------------------------------------
	// bucket arithmetic
	// -------------------------------------------------------------------
	wire at_cap  = (acc >= cap);
	wire fill    = t.tick & cyc_failed;
	wire [REG_W-1:0] filled  = at_cap ? cap : acc + 1'b1;
	wire [REG_W-1:0] drained = (acc == '0) ? '0 : acc - 1'b1;
	wire [REG_W-1:0] next_acc =
		fill    ? filled :
		t.drain ? drained :
		acc;

	// raising wins if the two thresholds overlap
	wire next_alarm =
		(next_acc >= upper) ? 1'b1 :
		(next_acc <= lower) ? 1'b0 :
		alarm;

	// -------------------------------------------------------------------
	// sticky events; a new event beats a clear in the same cycle
	// -------------------------------------------------------------------
	wire [EV_W-1:0] events;
	assign events[EV_RAISE] = next_alarm & ~alarm;
	assign events[EV_CLEAR] = ~next_alarm & alarm;
	assign events[EV_SAT]   = fill & at_cap;

	wire [EV_W-1:0] clr_mask = (wr_en & sel_clr) ? wbyte[EV_W-1:0] : '0;
	wire [EV_W-1:0] next_irq_stat = (irq_stat & ~clr_mask) | events;

	// -------------------------------------------------------------------
	// state update
	// -------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc      <= RST_ACC;
			alarm    <= 1'b0;
			level    <= RST_ACC;
			irq_stat <= RST_IRQ;
			irq      <= 1'b0;
		end
		else
		begin
			acc      <= next_acc;
			alarm    <= next_alarm;
			level    <= next_acc;
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_en);
		end
	end

	// -------------------------------------------------------------------
	// checks
	// -------------------------------------------------------------------
	logic first_cyc;

	// helper: marks the first edge after reset release
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			first_cyc <= 1'b1;
		else
			first_cyc <= 1'b0;
	end

	sequence s_fail_below_cap;
		t.tick && cyc_failed && (acc < cap);
	endsequence

	sequence s_fail_at_cap;
		t.tick && cyc_failed && (acc >= cap);
	endsequence

	sequence s_lower_read;
		setup && !pwrite && sel_lower ##1 access;
	endsequence

	AST_FILL_ONE:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_fail_below_cap |=> acc == $past(acc) + 8'h01)
		else $error("failed cycle did not add one");

	AST_DRAIN_FAST:
	assert property (@(posedge pclk) disable iff (!presetn)
		(t.tick && t.clean && t.code == 2'h0 && acc != 8'h00)
		|=> acc == $past(acc) - 8'h01)
		else $error("code 00 did not drain each clean cycle");

	AST_NO_TICKLESS:
	assert property (@(posedge pclk) disable iff (!presetn)
		!t.tick |=> acc == $past(acc))
		else $error("accumulator moved between cycles");

	AST_SATURATE:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_fail_at_cap |=> acc == $past(cap))
		else $error("accumulator passed the cap");

	AST_ALARM_CLEAR:
	assert property (@(posedge pclk) disable iff (!presetn)
		$fell(alarm) |-> acc <= lower && $past(t.tick))
		else $error("alarm cleared above lower threshold");

	AST_ALARM_RAISE:
	assert property (@(posedge pclk) disable iff (!presetn)
		(t.tick && next_acc >= upper) |=> alarm)
		else $error("alarm not raised at upper threshold");

	AST_LOWER_READ:
	assert property (@(posedge pclk) disable iff (!presetn)
		s_lower_read |-> prdata == {24'h000000, lower})
		else $error("lower threshold read back wrong");

	AST_DECAY_FIELD:
	assert property (@(posedge pclk) disable iff (!presetn)
		(wr_en && sel_decay) |=> decay == {6'h00, $past(pwdata[1:0])})
		else $error("decay register field wrong");

	AST_RESET_STATE:
	assert property (@(posedge pclk) disable iff (!presetn)
		first_cyc |-> acc == 8'h00 && !alarm)
		else $error("bucket not empty after reset");

	// the bus answer stands for one cycle, so a master that starts its
	// next setup at once is never taken as a second access
	AST_READY_PULSE:
	assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready stood for more than one cycle");

	AST_ERR_WITH_READY:
	assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error response without pready");

	AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
		irq == |($past(next_irq_stat) & $past(irq_en)))
		else $error("interrupt out of step with status");

endmodule : lbm_top

// ### pkg/lbm_pkg.sv
// leaky bucket activity monitor: shared constants, register map and helpers
// assumes a 10 MHz pclk and APB with 32-bit data; register indices map to
// byte addresses as four times the index
package lbm_pkg;

	// -------------------------------------------------------------------
	// bus geometry
	// -------------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// -------------------------------------------------------------------
	// register indices (byte address is index times four)
	// -------------------------------------------------------------------
	localparam logic [7:0] IDX_UPPER    = 8'h50;
	localparam logic [7:0] IDX_LOWER    = 8'h51;
	localparam logic [7:0] IDX_CAP      = 8'h52;
	localparam logic [7:0] IDX_DECAY    = 8'h53;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h60;
	localparam logic [7:0] IDX_IRQ_CLR  = 8'h61;
	localparam logic [7:0] IDX_IRQ_EN   = 8'h62;
	localparam logic [7:0] IDX_LEVEL    = 8'h63;

	// -------------------------------------------------------------------
	// reset values
	// -------------------------------------------------------------------
	localparam logic [7:0] RST_UPPER  = 8'h06;
	localparam logic [7:0] RST_LOWER  = 8'h04;
	localparam logic [7:0] RST_CAP    = 8'h08;
	localparam logic [7:0] RST_DECAY  = 8'h01;
	localparam logic [7:0] RST_ACC    = 8'h00;
	localparam logic [2:0] RST_IRQ    = 3'h0;

	// -------------------------------------------------------------------
	// field positions
	// -------------------------------------------------------------------
	localparam int DECAY_LSB = 0;
	localparam int DECAY_W   = 2;
	localparam int EV_RAISE  = 0;
	localparam int EV_CLEAR  = 1;
	localparam int EV_SAT    = 2;
	localparam int EV_W      = 3;
	localparam int LVL_ALARM = 8;

	// -------------------------------------------------------------------
	// timing
	// -------------------------------------------------------------------
	localparam int CLK_HZ     = 10_000_000;
	localparam int CYCLE_MS   = 128;
	localparam int CYCLE_CLKS = CYCLE_MS * (CLK_HZ / 1000);
	localparam int RUN_W      = 3;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] lbm_byte_addr(
		input logic [7:0] idx
	);
		lbm_byte_addr = {2'b00, idx, 2'b00};
	endfunction : lbm_byte_addr

endpackage : lbm_pkg

// ### pkg/lbm_tick_if.sv
// leaky bucket activity monitor: carrier between core, timer and decay
// assumes all parties share pclk
`timescale 1ns/1ns
interface lbm_tick_if;
	logic       tick;   // one-cycle pulse at each monitoring cycle end
	logic       clean;  // the ending cycle saw no failure
	logic [1:0] code;   // decay code
	logic       drain;  // one-cycle decrement request

	modport timer (output tick);
	modport decay (input tick, input clean, input code, output drain);
	modport core  (input tick, input drain, output clean, output code);
endinterface : lbm_tick_if

// ### tb/test_leaky_bucket_activity_monitor.sv
// bench for the leaky bucket monitor: APB register checks, fill and drain
// assumes lbm_top with a 20-clock monitoring cycle and one pclk domain
`timescale 1ns/1ns
module test_leaky_bucket_activity_monitor
	import lbm_pkg::*;
;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	localparam int CYC   = 20;
	localparam int LIMIT = 6000;
	logic              pclk, presetn, psel, penable, pwrite, input_fail;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, d;
	logic              pready, pslverr, alarm, irq, e;
	logic [REG_W-1:0]  level;
	int                fails, comparisons, clocks, n;
	logic [7:0]        ridx [8] = '{8'h50, 8'h51, 8'h52, 8'h53,
	                                8'h60, 8'h61, 8'h62, 8'h63};
	logic [7:0]        rval [8] = '{8'h06, 8'h04, 8'h08, 8'h01,
	                                8'h00, 8'h00, 8'h00, 8'h00};

	// clock and a hang guard; short cycle keeps the run brief
	initial pclk = 1'b0;
	always #50 pclk = ~pclk;
	always @(posedge pclk)
	begin
		clocks <= clocks + 1;
		if (clocks == LIMIT)
		begin
			fails = fails + 1;
			test_done();
		end
	end

	lbm_top #(.CYCLE_CLKS_P(CYC), .CNT_W(21)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .input_fail(input_fail),
		.alarm(alarm), .level(level), .irq(irq)
	);

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic test_done;
		if (fails == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one APB transfer; request held until pready is seen high at an edge;
	// values read right after the edge are those that stood before it
	task automatic xfer(input logic w, input logic [7:0] idx,
		input logic [31:0] wd);
		int k = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no local limit: only the bench timeout ends a hung wait
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
			k++;
		end
		d = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// the answer is due in the first access cycle
		check("pready wait", 32'h0, k);
	endtask : xfer

	task automatic wr(input logic [7:0] idx, input logic [7:0] v,
		input logic err);
		xfer(1'b1, idx, {24'h0, v});
		check($sformatf("wr err %h", idx), {31'h0, err}, {31'h0, e});
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [31:0] v,
		input logic err);
		xfer(1'b0, idx, 32'h0);
		check($sformatf("rd %h", idx), v, d);
		check($sformatf("rd err %h", idx), {31'h0, err}, {31'h0, e});
	endtask : rd

	// counts clocks until the accumulator moves; bounded
	task automatic wait_change(output int cnt);
		logic [7:0] old;
		old = level;
		cnt = 0;
		while (level === old && cnt < 10 * CYC)
		begin
			@(negedge pclk);
			cnt++;
		end
	endtask : wait_change

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial
	begin
		{psel, penable, pwrite, input_fail, presetn} = 5'h0;
		paddr       = '0;
		pwdata      = '0;
		fails       = 0;
		comparisons = 0;
		clocks      = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		check("level", 32'h0, {24'h0, level});
		check("alarm", 32'h0, {31'h0, alarm});
		// reset values of every register
		for (int i = 0; i < 8; i++)
			rd(ridx[i], {24'h0, rval[i]}, 1'b0);
		wr(IDX_DECAY, 8'hff, 1'b0);
		rd(IDX_DECAY, 32'h3, 1'b0);
		wr(IDX_LOWER, 8'ha5, 1'b0);
		rd(IDX_LOWER, 32'ha5, 1'b0);
		wr(IDX_LOWER, 8'h04, 1'b0);
		wr(IDX_CAP, 8'h3c, 1'b0);
		rd(IDX_CAP, 32'h3c, 1'b0);
		wr(IDX_CAP, 8'h08, 1'b0);
		// refused accesses: read-only place and unmapped word
		wr(IDX_LEVEL, 8'h55, 1'b1);
		rd(8'h70, 32'h0, 1'b1);
		wr(IDX_IRQ_EN, 8'h07, 1'b0);
		// fill: one count per failed cycle, alarm raised at six
		input_fail <= 1'b1;
		for (int k = 1; k <= 8; k++)
		begin
			wait_change(n);
			if (k > 1)
				check("fill interval", CYC, n);
			check("level", k, {24'h0, level});
			check("alarm", k >= 6, {31'h0, alarm});
			check("irq", k >= 6, {31'h0, irq});
		end
		// further failed cycles must not pass the cap
		repeat (3 * CYC) @(negedge pclk);
		check("level", 32'h8, {24'h0, level});
		rd(IDX_LEVEL, 32'h108, 1'b0);
		rd(IDX_IRQ_STAT, 32'h5, 1'b0);
		// slowest code first, so nothing drains while events are cleared
		wr(IDX_DECAY, 8'h03, 1'b0);
		input_fail <= 1'b0;
		repeat (3 * CYC) @(negedge pclk);
		wr(IDX_IRQ_CLR, 8'h07, 1'b0);
		rd(IDX_IRQ_STAT, 32'h0, 1'b0);
		check("irq", 32'h0, {31'h0, irq});
		// drain with every code: interval between decrements
		for (int c = 0; c < 4; c++)
		begin
			wr(IDX_DECAY, c[7:0], 1'b0);
			wait_change(n);
			check("alarm", (7 - 2 * c) > 4, {31'h0, alarm});
			wait_change(n);
			check("drain interval", (1 << c) * CYC, n);
			check("level", 6 - 2 * c, {24'h0, level});
			check("alarm", (6 - 2 * c) > 4, {31'h0, alarm});
		end
		// empty bucket stays at zero
		repeat (10 * CYC) @(negedge pclk);
		check("level", 32'h0, {24'h0, level});
		rd(IDX_IRQ_STAT, 32'h2, 1'b0);
		check("irq", 32'h1, {31'h0, irq});
		// masking drops the line, clearing empties the status
		wr(IDX_IRQ_EN, 8'h00, 1'b0);
		repeat (2) @(negedge pclk);
		check("irq", 32'h0, {31'h0, irq});
		wr(IDX_IRQ_CLR, 8'h02, 1'b0);
		rd(IDX_IRQ_STAT, 32'h0, 1'b0);
		test_done();
	end

endmodule : test_leaky_bucket_activity_monitor
